/* design/lcd_port_pkg.sv */
// shared constants for the split-strobe lcd host port
package lcd_port_pkg;
    // =========================================================
    // bus widths
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int UADDR_W = 5;
    localparam int UDATA_W = 32;
    // =========================================================
    // controller window in host physical space
    localparam logic [31:0] WIN_BASE = 32'h133e_0000;
    localparam logic [31:0] WIN_BYTES = 32'h0002_0000;
    localparam logic [31:0] WIN_MIN_BYTES = 32'h0001_0000;
    localparam logic [31:0] WIN_MAX_BYTES = 32'h0008_0000;
    // =========================================================
    // device decode: register block, then display memory
    localparam logic [16:0] REG_SPAN = 17'h0_0020;
    localparam int REG_WORDS = 16;
    localparam int MEM_WORDS = 256;
    localparam logic [2:0] MODE_SPLIT16 = 3'h7;
    localparam logic [15:0] BUS_IDLE_LEVEL = 16'hffff;
    // =========================================================
    // host command port offsets and fields
    localparam logic [4:0] OFS_ADDR = 5'h00;
    localparam logic [4:0] OFS_WDATA = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0c;
    localparam logic [4:0] OFS_RDATA = 5'h10;
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_WORD = 2;
    // =========================================================
    // host timing, in clk cycles of 25 ns
    localparam int CLK_NS = 25;
    localparam int SETUP_NS = 50;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_NS = 300;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS = 400;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int LINK_RST_CYC = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
    localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RECOVER_CYC);
    localparam logic [CNT_W-1:0] LINK_RST_CNT = CNT_W'(LINK_RST_CYC);
endpackage : lcd_port_pkg

/* design/lcd_bus_if.sv */
// the memory-style link between host and lcd controller
`timescale 1ns/1ps
interface lcd_bus_if;
    logic host_bus_clock;
    logic link_reset;
    logic [16:0] host_addr_in;
    logic lcd_window_select_n;
    logic mem_read_cmd_n;
    logic mem_write_cmd_n;
    logic host_high_byte_enable_n;
    logic bus_status_n;
    logic rd_wr_dir;
    logic cycle_ready;
    logic sixteen_bit_ack_n;
    logic [15:0] host_dout;
    logic host_doe;
    logic [15:0] dev_dout;
    logic dev_doe;
    logic [15:0] host_data_io;
    // =========================================================
    // resolved data bus level
    assign host_data_io = dev_doe ? dev_dout :
        (host_doe ? host_dout : lcd_port_pkg::BUS_IDLE_LEVEL);

    modport host (
        output host_bus_clock, link_reset, host_addr_in,
        output lcd_window_select_n, mem_read_cmd_n, mem_write_cmd_n,
        output host_high_byte_enable_n, bus_status_n, rd_wr_dir,
        output host_dout, host_doe,
        input cycle_ready, sixteen_bit_ack_n, host_data_io
    );
    modport device (
        input host_bus_clock, link_reset, host_addr_in,
        input lcd_window_select_n, mem_read_cmd_n, mem_write_cmd_n,
        input host_high_byte_enable_n, bus_status_n, rd_wr_dir,
        input host_data_io,
        output cycle_ready, sixteen_bit_ack_n, dev_dout, dev_doe
    );
endinterface : lcd_bus_if

/* design/lcd_host_end.sv */
// host end: drives memory cycles into the controller window
`timescale 1ns/1ps
module lcd_host_end (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command port
    input wire logic [4:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic cmd_write,
    input wire logic cmd_read,
    output logic [31:0] cmd_rdata,
    // link
    lcd_bus_if.host bus
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_CMD = 3'b010,
        H_DONE = 3'b011,
        H_RECOVER = 3'b100
    } hstate_type;

    hstate_type state_ff, nxt_state;
    logic [31:0] addr_ff;
    logic [15:0] wdata_ff, rdata_ff;
    logic rd_op_ff, word_op_ff, busy_ff, done_ff, win_err_ff, ack16_ff;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [4:0] rst_cnt_ff;
    logic link_rst_ff, bclk_ff;
    logic cs_n_ff, rd_n_ff, wr_n_ff, ube_n_ff, doe_ff;
    logic [31:0] cmd_rdata_ff;
    logic rdy_s1_ff, rdy_s2_ff, ack_s1_ff, ack_s2_ff;
    logic [15:0] dat_s1_ff, dat_s2_ff;
    // =========================================================
    // decode
    wire [31:0] win_ofs = cmd_wdata - lcd_port_pkg::WIN_BASE;
    wire in_window = (cmd_wdata >= lcd_port_pkg::WIN_BASE) &&
        (win_ofs < lcd_port_pkg::WIN_BYTES);
    wire win_size_ok = (lcd_port_pkg::WIN_BYTES >= lcd_port_pkg::WIN_MIN_BYTES)
        && (lcd_port_pkg::WIN_BYTES <= lcd_port_pkg::WIN_MAX_BYTES);
    wire wr_addr = cmd_write && (cmd_addr == lcd_port_pkg::OFS_ADDR);
    wire wr_wdata = cmd_write && (cmd_addr == lcd_port_pkg::OFS_WDATA);
    wire wr_ctrl = cmd_write && (cmd_addr == lcd_port_pkg::OFS_CTRL);
    wire go = wr_ctrl && cmd_wdata[lcd_port_pkg::CTRL_GO] && !busy_ff &&
        !link_rst_ff && !win_err_ff;
    wire cnt_zero = (cnt_ff == '0);
    wire [31:0] status_word = {27'h0, ack16_ff, 1'b0, win_err_ff, done_ff,
        busy_ff};
    wire [31:0] rd_mux =
        (cmd_addr == lcd_port_pkg::OFS_ADDR) ? addr_ff :
        (cmd_addr == lcd_port_pkg::OFS_WDATA) ? {16'h0, wdata_ff} :
        (cmd_addr == lcd_port_pkg::OFS_STATUS) ? status_word :
        (cmd_addr == lcd_port_pkg::OFS_RDATA) ? {16'h0, rdata_ff} : 32'h0;
    // =========================================================
    // cycle sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff - 5'h01;
        unique case (state_ff)
            H_IDLE: begin
                nxt_cnt = lcd_port_pkg::SETUP_CNT;
                if (go) begin
                    nxt_state = H_SETUP;
                end
            end
            H_SETUP: begin
                if (cnt_zero) begin
                    nxt_state = H_CMD;
                    nxt_cnt = lcd_port_pkg::HOLD_CNT;
                end
            end
            H_CMD: begin
                if (!cnt_zero) begin
                    nxt_cnt = cnt_ff - 5'h01;
                end else begin
                    nxt_cnt = cnt_ff;
                    if (rdy_s2_ff) begin
                        nxt_state = H_DONE;
                    end
                end
            end
            H_DONE: begin
                nxt_state = H_RECOVER;
                nxt_cnt = lcd_port_pkg::RECOVER_CNT;
            end
            H_RECOVER: begin
                if (cnt_zero) begin
                    nxt_state = H_IDLE;
                end
            end
            default: nxt_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        rdy_s1_ff <= bus.cycle_ready;
        rdy_s2_ff <= rdy_s1_ff;
        ack_s1_ff <= bus.sixteen_bit_ack_n;
        ack_s2_ff <= ack_s1_ff;
        dat_s1_ff <= bus.host_data_io;
        dat_s2_ff <= dat_s1_ff;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= H_IDLE;
            cnt_ff <= '0;
            rst_cnt_ff <= lcd_port_pkg::LINK_RST_CNT;
            link_rst_ff <= 1'b1;
            bclk_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rst_cnt_ff <= (rst_cnt_ff == '0) ? rst_cnt_ff : rst_cnt_ff - 5'h01;
            link_rst_ff <= (rst_cnt_ff != '0);
            bclk_ff <= ~bclk_ff;
        end
    end
    // =========================================================
    // command registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_ff <= lcd_port_pkg::WIN_BASE;
            wdata_ff <= '0;
            rd_op_ff <= 1'b0;
            word_op_ff <= 1'b1;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            win_err_ff <= 1'b0;
            rdata_ff <= '0;
            ack16_ff <= 1'b0;
            cmd_rdata_ff <= '0;
        end else begin
            cmd_rdata_ff <= cmd_read ? rd_mux : 32'h0;
            if (wr_addr && !busy_ff) begin
                addr_ff <= cmd_wdata;
                win_err_ff <= !(in_window && win_size_ok);
            end
            if (wr_wdata && !busy_ff) begin
                wdata_ff <= cmd_wdata[15:0];
            end
            if (go) begin
                rd_op_ff <= cmd_wdata[lcd_port_pkg::CTRL_READ];
                word_op_ff <= cmd_wdata[lcd_port_pkg::CTRL_WORD];
                busy_ff <= 1'b1;
            end else if (state_ff == H_RECOVER && cnt_zero) begin
                busy_ff <= 1'b0;
            end
            if (state_ff == H_DONE) begin
                done_ff <= 1'b1;
                ack16_ff <= !ack_s2_ff;
                if (rd_op_ff) begin
                    rdata_ff <= dat_s2_ff;
                end
            end else if (go) begin
                done_ff <= 1'b0;
            end
        end
    end
    // =========================================================
    // link pins
    wire sel = (state_ff == H_SETUP) || (state_ff == H_CMD);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            ube_n_ff <= 1'b1;
            doe_ff <= 1'b0;
        end else begin
            cs_n_ff <= !(nxt_state == H_SETUP || nxt_state == H_CMD);
            rd_n_ff <= !(nxt_state == H_CMD && rd_op_ff);
            wr_n_ff <= !(nxt_state == H_CMD && !rd_op_ff);
            ube_n_ff <= !((nxt_state == H_SETUP || nxt_state == H_CMD) &&
                word_op_ff);
            doe_ff <= (nxt_state == H_SETUP || nxt_state == H_CMD) &&
                !rd_op_ff;
        end
    end

    assign cmd_rdata = cmd_rdata_ff;
    assign bus.host_bus_clock = bclk_ff;
    assign bus.link_reset = link_rst_ff;
    assign bus.host_addr_in = addr_ff[16:0];
    assign bus.lcd_window_select_n = cs_n_ff;
    assign bus.mem_read_cmd_n = rd_n_ff;
    assign bus.mem_write_cmd_n = wr_n_ff;
    assign bus.host_high_byte_enable_n = ube_n_ff;
    assign bus.bus_status_n = 1'b1;
    assign bus.rd_wr_dir = 1'b1;
    assign bus.host_dout = wdata_ff;
    assign bus.host_doe = doe_ff;
endmodule : lcd_host_end

/* design/lcd_device_end.sv */
// lcd controller end of the split-strobe 16-bit host port
// Notes on behaviour
// - one 128 Kbyte window, registers then memory
// - host places window at fixed physical range
// - host window size 64 to 512 KB
// - host holds select low whole access
// - host asserts read or write, never both
// - ready low adds wait states until done
// - high byte enable picks word or byte
// - both sides follow memory cycle conventions
// - sixteen data and seventeen address lines
// - external select, shared high enable, split strobes
// - host chooses word or byte access
// - hold host off during display fetch arbitration
// - high strobe picks word or byte, address bit 0 the byte, on the low lane; strobes direction
// - straps sampled at reset release pick mode
// - endian strap zero little, one big
`timescale 1ns/1ps
module lcd_device_end (
    // link
    lcd_bus_if.device bus,
    // straps and display side
    input wire logic [2:0] bus_mode_straps,
    input wire logic endian_strap,
    input wire logic display_fetch_busy,
    // configuration seen
    output logic mode_ok,
    output logic big_endian,
    output logic host_access_active
);
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_ARB = 2'b01,
        D_DONE = 2'b10
    } dstate_type;

    dstate_type state_ff, nxt_state;
    logic [15:0] reg_mem [lcd_port_pkg::REG_WORDS];
    logic [15:0] disp_mem [lcd_port_pkg::MEM_WORDS];
    logic rst_s1_ff, rst_s2_ff;
    logic cs_s1_ff, cs_s2_ff, rd_s1_ff, rd_s2_ff, wr_s1_ff, wr_s2_ff;
    logic ube_s1_ff, ube_s2_ff, fb_s1_ff, fb_s2_ff;
    logic [16:0] adr_s1_ff, adr_s2_ff;
    logic [15:0] dat_s1_ff, dat_s2_ff;
    logic [2:0] mode_s1_ff, mode_s2_ff;
    logic end_s1_ff, end_s2_ff, bs_s1_ff, bs_s2_ff;
    logic mode_ok_ff, big_endian_ff, active_ff;
    logic ready_ff, ack16_n_ff, doe_ff;
    logic [15:0] dout_ff;
    // =========================================================
    // byte swap for big-endian order
    function automatic logic [15:0] swap_bytes(input logic [15:0] w);
        swap_bytes = {w[7:0], w[15:8]};
    endfunction : swap_bytes
    // =========================================================
    // link input synchronisers
    always_ff @(posedge bus.host_bus_clock) begin
        rst_s1_ff <= bus.link_reset;
        rst_s2_ff <= rst_s1_ff;
        cs_s1_ff <= bus.lcd_window_select_n;
        cs_s2_ff <= cs_s1_ff;
        rd_s1_ff <= bus.mem_read_cmd_n;
        rd_s2_ff <= rd_s1_ff;
        wr_s1_ff <= bus.mem_write_cmd_n;
        wr_s2_ff <= wr_s1_ff;
        ube_s1_ff <= bus.host_high_byte_enable_n;
        ube_s2_ff <= ube_s1_ff;
        adr_s1_ff <= bus.host_addr_in;
        adr_s2_ff <= adr_s1_ff;
        dat_s1_ff <= bus.host_data_io;
        dat_s2_ff <= dat_s1_ff;
        fb_s1_ff <= display_fetch_busy;
        fb_s2_ff <= fb_s1_ff;
        mode_s1_ff <= bus_mode_straps;
        mode_s2_ff <= mode_s1_ff;
        end_s1_ff <= endian_strap;
        end_s2_ff <= end_s1_ff;
        bs_s1_ff <= bus.bus_status_n;
        bs_s2_ff <= bs_s1_ff;
    end
    // =========================================================
    // cycle decode
    wire link_rst = rst_s2_ff;
    wire selected = !cs_s2_ff && mode_ok_ff;
    wire rd_req = selected && !rd_s2_ff;
    wire wr_req = selected && !wr_s2_ff;
    wire cmd_req = rd_req ^ wr_req;
    wire cmd_gone = cs_s2_ff || (rd_s2_ff && wr_s2_ff);
    wire [16:0] adr = adr_s2_ff;
    wire reg_hit = (adr < lcd_port_pkg::REG_SPAN);
    wire [3:0] reg_idx = adr[4:1];
    wire [7:0] mem_idx = adr[8:1];
    wire [15:0] cur_word = reg_hit ? reg_mem[reg_idx] : disp_mem[mem_idx];
    wire word_acc = !ube_s2_ff;
    wire [15:0] word_in = big_endian_ff ? swap_bytes(dat_s2_ff) : dat_s2_ff;
    wire [15:0] byte_merge = adr[0] ? {dat_s2_ff[7:0], cur_word[7:0]} :
        {cur_word[15:8], dat_s2_ff[7:0]};
    wire [15:0] wr_word = word_acc ? word_in : byte_merge;
    wire [15:0] word_out = big_endian_ff ? swap_bytes(cur_word) : cur_word;
    wire [15:0] byte_out = adr[0] ? {8'h00, cur_word[15:8]} :
        {8'h00, cur_word[7:0]};
    wire [15:0] rd_word = word_acc ? word_out : byte_out;
    wire arb_free = !fb_s2_ff;
    wire do_write = (state_ff == D_ARB) && arb_free && wr_req;
    // =========================================================
    // access sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            D_IDLE: begin
                if (cmd_req) begin
                    nxt_state = D_ARB;
                end
            end
            D_ARB: begin
                if (cmd_gone) begin
                    nxt_state = D_IDLE;
                end else if (arb_free) begin
                    nxt_state = D_DONE;
                end
            end
            D_DONE: begin
                if (cmd_gone) begin
                    nxt_state = D_IDLE;
                end
            end
            default: nxt_state = D_IDLE;
        endcase
    end

    always_ff @(posedge bus.host_bus_clock) begin
        if (link_rst) begin
            state_ff <= D_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // =========================================================
    // mode straps caught while reset is held
    always_ff @(posedge bus.host_bus_clock) begin
        if (link_rst) begin
            mode_ok_ff <= (mode_s2_ff == lcd_port_pkg::MODE_SPLIT16) &&
                bs_s2_ff;
            big_endian_ff <= end_s2_ff;
        end
    end
    // =========================================================
    // storage
    always_ff @(posedge bus.host_bus_clock) begin
        if (do_write && reg_hit) begin
            reg_mem[reg_idx] <= wr_word;
        end
        if (do_write && !reg_hit) begin
            disp_mem[mem_idx] <= wr_word;
        end
    end
    // =========================================================
    // link outputs
    always_ff @(posedge bus.host_bus_clock) begin
        if (link_rst) begin
            ready_ff <= 1'b1;
            ack16_n_ff <= 1'b1;
            doe_ff <= 1'b0;
            dout_ff <= '0;
            active_ff <= 1'b0;
        end else begin
            ready_ff <= !(nxt_state == D_ARB);
            ack16_n_ff <= !selected;
            doe_ff <= (nxt_state == D_DONE) && rd_req;
            if (state_ff == D_ARB && arb_free && rd_req) begin
                dout_ff <= rd_word;
            end
            active_ff <= (nxt_state != D_IDLE);
        end
    end

    assign bus.cycle_ready = ready_ff;
    assign bus.sixteen_bit_ack_n = ack16_n_ff;
    assign bus.dev_dout = dout_ff;
    assign bus.dev_doe = doe_ff;
    assign mode_ok = mode_ok_ff;
    assign big_endian = big_endian_ff;
    assign host_access_active = active_ff;
endmodule : lcd_device_end

/* sim/lcd_port_chk.sv */
// link protocol checker for the host and controller ends
`timescale 1ns/1ps
module lcd_port_chk (
    // link clock and reset
    input wire logic host_bus_clock,
    input wire logic link_reset,
    // host side
    input wire logic lcd_window_select_n,
    input wire logic mem_read_cmd_n,
    input wire logic mem_write_cmd_n,
    input wire logic bus_status_n,
    input wire logic rd_wr_dir,
    // device side
    input wire logic cycle_ready,
    input wire logic sixteen_bit_ack_n,
    input wire logic [15:0] dev_dout,
    input wire logic dev_doe
);
    default clocking cb @(posedge host_bus_clock);
    endclocking
    default disable iff (link_reset);
    // ==========
    // host side
    a_one_command: assert property (
        mem_read_cmd_n || mem_write_cmd_n)
        else $error("both commands low");
    a_cmd_selected: assert property (
        !(mem_read_cmd_n && mem_write_cmd_n) |-> !lcd_window_select_n)
        else $error("command without select");
    a_status_tied: assert property (
        bus_status_n && rd_wr_dir)
        else $error("status or direction low");
    a_release_ready: assert property (
        $rose(lcd_window_select_n) |-> $past(cycle_ready))
        else $error("select released during wait");
    // ==========
    // device side
    a_wait_inserted: assert property (
        $fell(mem_write_cmd_n) || $fell(mem_read_cmd_n)
        |-> ##[1:4] !cycle_ready)
        else $error("no wait state");
    a_wait_in_access: assert property (
        !cycle_ready |-> !lcd_window_select_n && !sixteen_bit_ack_n)
        else $error("wait outside selected access");
    a_ack_selected: assert property (
        !lcd_window_select_n [*4] |-> !sixteen_bit_ack_n)
        else $error("sixteen bit ack missing");
    a_doe_on_read: assert property (
        $rose(dev_doe) |-> !mem_read_cmd_n && !lcd_window_select_n)
        else $error("data driven outside read");
    a_no_doe_write: assert property (
        !mem_write_cmd_n |-> !dev_doe)
        else $error("data driven in write");
    a_data_hold: assert property (
        dev_doe && $past(dev_doe) |-> $stable(dev_dout))
        else $error("read data moved");
    cover property ($fell(cycle_ready));
    cover property ($rose(dev_doe));
    cover property (!mem_write_cmd_n && !lcd_window_select_n);
endmodule : lcd_port_chk

/* sim/tb.sv */
// self-checking bench for the host and controller ends
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic bclk_2 = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] cmd_addr = 5'h00;
    logic [31:0] cmd_wdata = 32'h0;
    logic cmd_write = 1'b0;
    logic cmd_read = 1'b0;
    logic [31:0] cmd_rdata;
    logic [2:0] straps = 3'h7;
    logic [2:0] straps_2 = 3'h6;
    logic endian_sel = 1'b0;
    logic fetch_busy = 1'b0;
    logic mode_ok;
    logic mode_ok_2;
    logic big_endian;
    logic access_active;
    logic [31:0] rd;
    logic [15:0] seen_wd;
    logic seen_ube;
    logic [16:0] seen_addr;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int ready_lows = 0;
    localparam logic [31:0] BASE = lcd_port_pkg::WIN_BASE;

    always #12.5 clk = ~clk;
    always #6 bclk_2 = ~bclk_2;
    // ==========
    // ends and checker
    lcd_bus_if u_lcd_bus_if ();
    lcd_bus_if u_lcd_bus_if_2 ();
    lcd_host_end u_lcd_host_end (.clk(clk), .sys_rst(sys_rst),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .bus(u_lcd_bus_if.host));
    lcd_device_end u_lcd_device_end (.bus(u_lcd_bus_if.device),
        .bus_mode_straps(straps), .endian_strap(endian_sel),
        .display_fetch_busy(fetch_busy), .mode_ok(mode_ok),
        .big_endian(big_endian), .host_access_active(access_active));
    lcd_device_end u_lcd_device_end_2 (.bus(u_lcd_bus_if_2.device),
        .bus_mode_straps(straps_2), .endian_strap(endian_sel),
        .display_fetch_busy(fetch_busy), .mode_ok(mode_ok_2),
        .big_endian(), .host_access_active());
    lcd_port_chk u_lcd_port_chk (
        .host_bus_clock(u_lcd_bus_if.host_bus_clock),
        .link_reset(u_lcd_bus_if.link_reset),
        .lcd_window_select_n(u_lcd_bus_if.lcd_window_select_n),
        .mem_read_cmd_n(u_lcd_bus_if.mem_read_cmd_n),
        .mem_write_cmd_n(u_lcd_bus_if.mem_write_cmd_n),
        .bus_status_n(u_lcd_bus_if.bus_status_n),
        .rd_wr_dir(u_lcd_bus_if.rd_wr_dir),
        .cycle_ready(u_lcd_bus_if.cycle_ready),
        .sixteen_bit_ack_n(u_lcd_bus_if.sixteen_bit_ack_n),
        .dev_dout(u_lcd_bus_if.dev_dout),
        .dev_doe(u_lcd_bus_if.dev_doe));
    assign u_lcd_bus_if_2.host_bus_clock = bclk_2;
    assign u_lcd_bus_if_2.bus_status_n = 1'b1;
    assign u_lcd_bus_if_2.rd_wr_dir = 1'b1;
    assign u_lcd_bus_if_2.host_doe = 1'b0;
    assign u_lcd_bus_if_2.host_addr_in = 17'h00040;
    assign u_lcd_bus_if_2.host_high_byte_enable_n = 1'b0;
    // ==========
    // wire monitor and timeout
    always @(posedge clk) begin
        cycles++;
        if (u_lcd_bus_if.cycle_ready === 1'b0) ready_lows++;
        if (u_lcd_bus_if.mem_write_cmd_n === 1'b0) begin
            seen_wd <= u_lcd_bus_if.host_data_io;
            seen_ube <= u_lcd_bus_if.host_high_byte_enable_n;
            seen_addr <= u_lcd_bus_if.host_addr_in;
        end
        if (cycles > 20000) begin
            chk(1'b0, "timeout");
            end_sim();
        end
    end
    // ==========
    // tasks
    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : chk

    task automatic cmd_wr(input logic [4:0] a, input logic [31:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_write <= 1'b1;
        @(posedge clk);
        cmd_write <= 1'b0;
        @(posedge clk);
    endtask : cmd_wr

    task automatic cmd_rd(input logic [4:0] a, output logic [31:0] d);
        cmd_addr <= a;
        cmd_read <= 1'b1;
        @(posedge clk);
        cmd_read <= 1'b0;
        @(negedge clk);
        d = cmd_rdata;
        @(posedge clk);
    endtask : cmd_rd

    task automatic access(input logic [31:0] a, input logic [15:0] d,
                          input logic [2:0] ctl);
        int n;
        n = 0;
        cmd_wr(lcd_port_pkg::OFS_ADDR, a);
        cmd_wr(lcd_port_pkg::OFS_WDATA, {16'h0, d});
        cmd_wr(lcd_port_pkg::OFS_CTRL, {29'h0, ctl});
        repeat (4) @(posedge clk);
        rd = 32'h0;
        while (rd[1:0] !== 2'b10 && n < 200) begin
            cmd_rd(lcd_port_pkg::OFS_STATUS, rd);
            n++;
        end
        chk(rd[1:0] === 2'b10, "access unfinished");
        chk(rd[4] === 1'b1, "no sixteen bit ack");
        cmd_rd(lcd_port_pkg::OFS_RDATA, rd);
    endtask : access

    task automatic wire_chk(input logic [15:0] d, input logic ube,
                            input logic [16:0] a);
        chk(seen_ube === ube && seen_addr === a, "strobe or address");
        chk(ube ? seen_wd[7:0] === d[7:0] : seen_wd === d, "bus data");
    endtask : wire_chk

    task automatic bad_cycle(input logic [2:0] s, input logic both);
        int bad;
        bad = 0;
        straps_2 <= s;
        u_lcd_bus_if_2.link_reset <= 1'b1;
        repeat (8) @(posedge bclk_2);
        u_lcd_bus_if_2.link_reset <= 1'b0;
        repeat (8) @(posedge bclk_2);
        u_lcd_bus_if_2.lcd_window_select_n <= 1'b0;
        u_lcd_bus_if_2.mem_write_cmd_n <= 1'b0;
        u_lcd_bus_if_2.mem_read_cmd_n <= ~both;
        repeat (16) begin
            @(posedge bclk_2);
            if (u_lcd_bus_if_2.cycle_ready !== 1'b1) bad++;
            if (u_lcd_bus_if_2.dev_doe !== 1'b0) bad++;
        end
        u_lcd_bus_if_2.lcd_window_select_n <= 1'b1;
        u_lcd_bus_if_2.mem_write_cmd_n <= 1'b1;
        u_lcd_bus_if_2.mem_read_cmd_n <= 1'b1;
        chk(bad == 0 && mode_ok_2 === (s == 3'h7), "cycle not ignored");
    endtask : bad_cycle

    task automatic restart();
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (40) @(posedge clk);
    endtask : restart

    task automatic end_sim();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // ==========
    // main sequence
    initial begin
        u_lcd_bus_if_2.link_reset = 1'b1;
        u_lcd_bus_if_2.lcd_window_select_n = 1'b1;
        u_lcd_bus_if_2.mem_read_cmd_n = 1'b1;
        u_lcd_bus_if_2.mem_write_cmd_n = 1'b1;
        restart();
        chk(mode_ok === 1'b1 && big_endian === 1'b0, "mode");
        chk(u_lcd_bus_if.bus_status_n === 1'b1, "status pin");
        access(BASE + 32'h40, 16'ha5c3, 3'h5);
        wire_chk(16'ha5c3, 1'b0, 17'h00040);
        chk(ready_lows > 0, "no wait states");
        access(BASE + 32'h240, 16'h0, 3'h7);
        chk(rd[15:0] === 16'ha5c3, "word read");
        access(BASE + 32'h41, 16'h003c, 3'h1);
        wire_chk(16'h003c, 1'b1, 17'h00041);
        access(BASE + 32'h40, 16'h0, 3'h7);
        chk(rd[15:0] === 16'h3cc3, "high lane");
        access(BASE + 32'h41, 16'h0, 3'h3);
        chk(rd[7:0] === 8'h3c, "byte read");
        access(BASE + lcd_port_pkg::WIN_BYTES - 2, 16'h5a0f, 3'h5);
        access(BASE + lcd_port_pkg::WIN_BYTES - 2, 16'h0, 3'h7);
        chk(rd[15:0] === 16'h5a0f, "window top");
        cmd_wr(lcd_port_pkg::OFS_ADDR, BASE - 32'h2);
        cmd_wr(lcd_port_pkg::OFS_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        cmd_rd(lcd_port_pkg::OFS_STATUS, rd);
        chk(rd[2] === 1'b1 && rd[0] === 1'b0, "window error");
        fetch_busy <= 1'b1;
        cmd_wr(lcd_port_pkg::OFS_ADDR, BASE + 32'h40);
        cmd_wr(lcd_port_pkg::OFS_CTRL, 32'h7);
        repeat (60) @(posedge clk);
        chk(u_lcd_bus_if.cycle_ready === 1'b0, "hold-off");
        chk(access_active === 1'b1, "device not in access");
        fetch_busy <= 1'b0;
        access(BASE + 32'h40, 16'h0, 3'h7);
        chk(rd[15:0] === 16'h3cc3, "held read");
        endian_sel <= 1'b1;
        restart();
        chk(big_endian === 1'b1, "endian");
        access(BASE + 32'h40, 16'ha5c3, 3'h5);
        access(BASE + 32'h40, 16'h0, 3'h3);
        chk(rd[7:0] === 8'ha5, "big endian lane");
        bad_cycle(3'h6, 1'b0);
        bad_cycle(3'h7, 1'b1);
        end_sim();
    end
endmodule : tb
